// ---- rtl/self_tune_timer.sv ----
// module: R divider and self-tuning sequencer of one PLL
`timescale 1ns/1ps
`default_nettype none
module self_tune_timer #(
  parameter int PD_PERIODS = synth_ctrl_pkg::TUNE_PERIODS,
  parameter int R_W        = synth_ctrl_pkg::DATA_W
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ref_tick,
  input  wire logic [R_W-1:0] r_div,
  input  wire logic           powered,
  input  wire logic           start,
  output logic                tuning,
  output logic                locked
);
  import synth_ctrl_pkg::*;

  localparam int CW = $clog2(PD_PERIODS + 1);

  if (PD_PERIODS < 1 || R_W < 2) begin : g_bad_param
    $error("self_tune_timer: unsupported parameters");
  end

  tune_state_e    state_reg;
  logic [R_W-1:0] r_cnt_reg;
  logic [CW-1:0]  pd_cnt_reg;
  logic           pd_tick;

  // an R value of 0 or 1 gives one update per reference edge
  assign pd_tick = ref_tick &&
    ((r_div <= R_W'(1)) || (r_cnt_reg >= r_div - R_W'(1)));

  //////////////////////////////////////////////////////////////////////////
  // reference divider, realigned when tuning restarts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_cnt_reg <= '0;
    end else if (start || pd_tick) begin
      r_cnt_reg <= '0;
    end else if (ref_tick) begin
      r_cnt_reg <= r_cnt_reg + R_W'(1);
    end
  end

  // tuning counts update periods, then the loop takes over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg  <= TS_OFF;
      pd_cnt_reg <= '0;
    end else if (!powered) begin
      state_reg  <= TS_OFF;
      pd_cnt_reg <= '0;
    end else if (start) begin
      state_reg  <= TS_TUNE;
      pd_cnt_reg <= '0;
    end else begin
      case (state_reg)
        TS_TUNE: begin
          if (pd_tick) begin
            pd_cnt_reg <= pd_cnt_reg + CW'(1);
            if (pd_cnt_reg == CW'(PD_PERIODS - 1)) begin
              state_reg <= TS_LOCK;
            end
          end
        end
        TS_OFF:  state_reg <= TS_OFF;
        TS_LOCK: state_reg <= TS_LOCK;
        default: state_reg <= TS_OFF;
      endcase
    end
  end

  assign tuning = (state_reg == TS_TUNE);
  assign locked = (state_reg == TS_LOCK);

  sequence s_last_period;
    tuning && pd_tick && pd_cnt_reg == CW'(PD_PERIODS - 1);
  endsequence
  a_tune_length : assert property (@(posedge clk) disable iff (rst)
    s_last_period ##0 (powered && !start) |=> locked)
    else $error("tuning did not end after its update periods");
  a_tune_bound : assert property (@(posedge clk) disable iff (rst)
    tuning |-> pd_cnt_reg < CW'(PD_PERIODS))
    else $error("tuning ran past its update periods");

endmodule : self_tune_timer
`default_nettype wire

// ---- rtl/serial_word_shifter.sv ----
// module: pin synchronisers and 22-bit shift register of the serial port
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  sclk_raw,
  input  wire logic                  serial_data_in_raw,
  input  wire logic                  sen_n_raw,
  output logic                       word_valid,
  output synth_ctrl_pkg::word_s      word
);
  import synth_ctrl_pkg::*;

  logic [2:0]        sclk_sync;
  logic [1:0]        serial_data_in_sync;
  logic [2:0]        sen_n_sync;
  logic [WORD_W-1:0] shift_reg;
  logic              sclk_rise;
  logic              sen_rise;

  //////////////////////////////////////////////////////////////////////////
  // two flops per pin, third flop only for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_sync  <= 3'h0;
      serial_data_in_sync <= 2'h0;
      sen_n_sync <= 3'h7;
    end else begin
      sclk_sync  <= {sclk_sync[1:0], sclk_raw};
      serial_data_in_sync <= {serial_data_in_sync[0], serial_data_in_raw};
      sen_n_sync <= {sen_n_sync[1:0], sen_n_raw};
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sen_rise  = sen_n_sync[1] & ~sen_n_sync[2];

  // shift only while enabled; old bits fall off the top
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg <= 22'h00_0000;
    end else if (sclk_rise && !sen_n_sync[1]) begin
      shift_reg <= {shift_reg[WORD_W-2:0], serial_data_in_sync[1]};
    end
  end

  // latch pulse carries the last 22 bits shifted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_valid <= 1'b0;
      word       <= '0;
    end else begin
      word_valid <= sen_rise;
      if (sen_rise) begin
        word <= shift_reg;
      end
    end
  end

  a_shift_in : assert property (@(posedge clk) disable iff (rst)
    sclk_rise && !sen_n_sync[1] |=> shift_reg[0] == $past(serial_data_in_sync[1]))
    else $error("bit not shifted in on clock rise");
  a_hold_disabled : assert property (@(posedge clk) disable iff (rst)
    sen_n_sync[1] |=> $stable(shift_reg))
    else $error("shift register moved while latch enable high");

endmodule : serial_word_shifter
`default_nettype wire

// ---- rtl/synth_ctrl_pkg.sv ----
// package: constants, types and rule overview of the synthesizer serial control
//
// Overview of operation
// - a programming word is 22 bits: 18 data bits and 4 address bits
// - while latch enable is low, data is shifted in on shift clock rises
// - latch enable rise copies data field into the addressed register
// - while latch enable is high, clock and data activity are ignored
// - leading don't-care bits allowed; only the last 22 bits are decoded
// - only one RF PLL is active; the most recently written one
// - self-tuning starts on PLL power-up, or on frequency change if powered
// - power-up by pin release or by power register bits both start tuning
// - tuning comes first; closed-loop control takes over afterwards
// - RF PLLs halve the oscillator before N, so feedback divides by 2N
// - the IF PLL feeds its oscillator straight to its N divider
// - the IF output divider divides by 1, 2, 4 or 8
// - register 0 bit D6 halves the reference input before the R dividers
// - lock margin warning goes low after tuning, high near range limit
// - lock margin warning stays high while either PLL is tuning
// - tuning lasts the first 13 phase detector periods, then loop control
// - aux output carries the lock margin warning when select is 011
// - writing an RF PLL's R or N register selects that PLL for output
// - the serial port keeps latching writes in every power-down mode
package synth_ctrl_pkg;

  // serial word layout
  localparam int WORD_W   = 22;
  localparam int DATA_W   = 18;
  localparam int ADDR_W   = 4;
  localparam int NUM_REGS = 16;

  // internal register addresses
  localparam logic [3:0] REG_MAIN  = 4'h0;
  localparam logic [3:0] REG_POWERDOWN_PIN_N  = 4'h2;
  localparam logic [3:0] REG_N_RFA = 4'h3;
  localparam logic [3:0] REG_N_RFB = 4'h4;
  localparam logic [3:0] REG_N_IF  = 4'h5;
  localparam logic [3:0] REG_R_RFA = 4'h6;
  localparam logic [3:0] REG_R_RFB = 4'h7;
  localparam logic [3:0] REG_R_IF  = 4'h8;

  // main configuration fields
  localparam int         MAIN_AUTOPU_BIT = 0;
  localparam int         MAIN_IFDIV_LSB  = 1;
  localparam int         MAIN_AUX_OUTPUT_SELECT_LSB = 3;
  localparam int         MAIN_HALVE_BIT  = 6;
  localparam logic [2:0] AUX_OUTPUT_SELECT_WARN     = 3'h3;

  // power register fields
  localparam int POWERDOWN_PIN_N_RF_BIT = 0;
  localparam int POWERDOWN_PIN_N_IF_BIT = 1;

  // self-tuning length in phase detector periods
  localparam int TUNE_PERIODS = 13;

  // wishbone map
  localparam int         WB_AW         = 8;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_FB_RF     = 8'h08;
  localparam logic [7:0] OFS_FB_IF     = 8'h0C;
  localparam logic [7:0] OFS_IFDIV     = 8'h10;
  localparam logic [7:0] OFS_SHADOW    = 8'h40;
  localparam int         CTRL_RETUNE   = 0;
  localparam int         ST_PWR_RF     = 0;
  localparam int         ST_PWR_IF     = 1;
  localparam int         ST_RF_B       = 2;
  localparam int         ST_LOCK_LSB   = 3;
  localparam int         ST_TUNE_LSB   = 6;
  localparam int         ST_WARN       = 9;

  // one programming word as shifted in, address last
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } word_s;

  // self-tuning sequencer states
  typedef enum logic [2:0] {
    TS_OFF  = 3'h1,
    TS_TUNE = 3'h2,
    TS_LOCK = 3'h4
  } tune_state_e;

endpackage : synth_ctrl_pkg

// ---- rtl/synth_serial_control.sv ----
// module: top of the synthesizer serial control with wishbone status port
`timescale 1ns/1ps
`default_nettype none
module synth_serial_control (
  input  wire logic                            REF_CLK,
  input  wire logic                            RST,
  input  wire logic                            SERIAL_SHIFT_CLOCK,
  input  wire logic                            SERIAL_DATA_IN,
  input  wire logic                            SERIAL_LATCH_ENABLE_N,
  input  wire logic                            POWERDOWN_PIN_N,
  input  wire logic                            REFERENCE_INPUT,
  input  wire logic [2:0]                      COMP_NEAR_LIMIT,
  input  wire logic                            WB_CYC_I,
  input  wire logic                            WB_STB_I,
  input  wire logic                            WB_WE_I,
  input  wire logic [synth_ctrl_pkg::WB_AW-1:0] WB_ADR_I,
  input  wire logic [3:0]                      WB_SEL_I,
  input  wire logic [31:0]                     WB_DAT_I,
  output logic      [31:0]                     WB_DAT_O,
  output logic                                 WB_ACK_O,
  output logic                                 AUX_OUTPUT_PIN,
  output logic                                 LOCK_MARGIN_WARNING_N,
  output logic                                 RF_PLL_B_ACTIVE
);
  import synth_ctrl_pkg::*;

  // pll index: 0 rf_pll_a, 1 rf_pll_b, 2 if pll
  localparam logic [11:0] N_ADDRS = {REG_N_IF, REG_N_RFB, REG_N_RFA};
  localparam logic [11:0] R_ADDRS = {REG_R_IF, REG_R_RFB, REG_R_RFA};

  logic              word_valid;
  word_s             lat_word;
  logic [DATA_W-1:0] shadow_reg [NUM_REGS];
  logic              rf_b_sel_reg;
  logic [1:0]        pdn_sync;
  logic [2:0]        ref_sync;
  logic [2:0]        near_s1;
  logic [2:0]        near_s2;
  logic              halve_phase_reg;
  logic              ref_tick;
  logic              pwr_rf;
  logic              pwr_if;
  logic [2:0]        powered;
  logic [2:0]        powered_prev_reg;
  logic [2:0]        freq_change;
  logic [2:0]        tune_start;
  logic [2:0]        tuning;
  logic [2:0]        locked;
  logic              retune_reg;
  logic              warn_next;
  logic [2:0]        aux_sel;
  logic [1:0]        ifdiv_code;
  logic [3:0]        ifdiv_ratio_reg;
  logic [DATA_W:0]   fb_rf_reg;
  logic [DATA_W-1:0] fb_if_reg;
  logic              wb_req;
  logic [31:0]       rd_next;

  //////////////////////////////////////////////////////////////////////////
  // serial port front end
  serial_word_shifter u_shifter (
    .clk        (REF_CLK),
    .rst        (RST),
    .sclk_raw   (SERIAL_SHIFT_CLOCK),
    .serial_data_in_raw  (SERIAL_DATA_IN),
    .sen_n_raw  (SERIAL_LATCH_ENABLE_N),
    .word_valid (word_valid),
    .word       (lat_word)
  );

  // latched words land in the addressed register whatever the power state
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        shadow_reg[i] <= 18'h0_0000;
      end
    end else if (word_valid) begin
      shadow_reg[lat_word.addr] <= lat_word.data;
    end
  end

  // the last written RF PLL drives the RF output
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rf_b_sel_reg <= 1'b0;
    end else if (word_valid) begin
      if (lat_word.addr == REG_N_RFB || lat_word.addr == REG_R_RFB) begin
        rf_b_sel_reg <= 1'b1;
      end else if (lat_word.addr == REG_N_RFA ||
                   lat_word.addr == REG_R_RFA) begin
        rf_b_sel_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers for power, reference and range-limit inputs
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pdn_sync <= 2'h0;
      ref_sync <= 3'h0;
      near_s1  <= 3'h0;
      near_s2  <= 3'h0;
    end else begin
      pdn_sync <= {pdn_sync[0], POWERDOWN_PIN_N};
      ref_sync <= {ref_sync[1:0], REFERENCE_INPUT};
      near_s1  <= COMP_NEAR_LIMIT;
      near_s2  <= near_s1;
    end
  end

  // optional halving keeps every second reference edge
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      halve_phase_reg <= 1'b0;
    end else if (ref_sync[1] && !ref_sync[2]) begin
      halve_phase_reg <= ~halve_phase_reg;
    end
  end

  assign ref_tick = ref_sync[1] && !ref_sync[2] &&
    (!shadow_reg[REG_MAIN][MAIN_HALVE_BIT] || halve_phase_reg);

  //////////////////////////////////////////////////////////////////////////
  // power state: pin low overrides the register bits
  assign pwr_rf = pdn_sync[1] &&
    (shadow_reg[REG_POWERDOWN_PIN_N][POWERDOWN_PIN_N_RF_BIT] ||
     shadow_reg[REG_MAIN][MAIN_AUTOPU_BIT]);
  assign pwr_if = pdn_sync[1] &&
    (shadow_reg[REG_POWERDOWN_PIN_N][POWERDOWN_PIN_N_IF_BIT] ||
     shadow_reg[REG_MAIN][MAIN_AUTOPU_BIT]);
  assign powered = {pwr_if, pwr_rf && rf_b_sel_reg,
                    pwr_rf && !rf_b_sel_reg};

  // remembers power for finding power-up edges
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      powered_prev_reg <= 3'h0;
    end else begin
      powered_prev_reg <= powered;
    end
  end

  // one tuning sequencer per PLL
  for (genvar p = 0; p < 3; p++) begin : g_pll
    assign freq_change[p] = word_valid &&
      (lat_word.addr == N_ADDRS[4*p +: 4] ||
       lat_word.addr == R_ADDRS[4*p +: 4]) &&
      lat_word.data != shadow_reg[lat_word.addr];
    assign tune_start[p] = powered[p] &&
      (!powered_prev_reg[p] || freq_change[p] || retune_reg);

    self_tune_timer #(
      .PD_PERIODS (TUNE_PERIODS),
      .R_W        (DATA_W)
    ) u_tune (
      .clk      (REF_CLK),
      .rst      (RST),
      .ref_tick (ref_tick),
      .r_div    (shadow_reg[R_ADDRS[4*p +: 4]]),
      .powered  (powered[p]),
      .start    (tune_start[p]),
      .tuning   (tuning[p]),
      .locked   (locked[p])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // warning: high while tuning, near range limit, or nothing locked
  assign warn_next = (|tuning) || (|(near_s2 & powered)) ||
                     !(|locked);
  assign aux_sel    = shadow_reg[REG_MAIN][MAIN_AUX_OUTPUT_SELECT_LSB +: 3];
  assign ifdiv_code = shadow_reg[REG_MAIN][MAIN_IFDIV_LSB +: 2];

  // pin outputs, registered
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LOCK_MARGIN_WARNING_N <= 1'b1;
      AUX_OUTPUT_PIN        <= 1'b0;
      RF_PLL_B_ACTIVE       <= 1'b0;
    end else begin
      LOCK_MARGIN_WARNING_N <= warn_next;
      AUX_OUTPUT_PIN        <= (aux_sel == AUX_OUTPUT_SELECT_WARN) ?
                               LOCK_MARGIN_WARNING_N : 1'b0;
      RF_PLL_B_ACTIVE       <= rf_b_sel_reg;
    end
  end

  // divider ratios seen by the phase detectors and the IF output
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      fb_rf_reg       <= 19'h0_0000;
      fb_if_reg       <= 18'h0_0000;
      ifdiv_ratio_reg <= 4'h1;
    end else begin
      fb_rf_reg <= rf_b_sel_reg ? {shadow_reg[REG_N_RFB], 1'b0} :
                                  {shadow_reg[REG_N_RFA], 1'b0};
      fb_if_reg       <= shadow_reg[REG_N_IF];
      ifdiv_ratio_reg <= 4'h1 << ifdiv_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, every address acknowledged
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // read multiplexer; unmapped words below the shadow window read zero, words above it alias the shadow registers
  always_comb begin
    rd_next = 32'h0000_0000;
    if (WB_ADR_I >= OFS_SHADOW) begin
      rd_next[DATA_W-1:0] = shadow_reg[WB_ADR_I[5:2]];
    end else begin
      case (WB_ADR_I)
        OFS_CTRL:   rd_next[CTRL_RETUNE] = retune_reg;
        OFS_STATUS: begin
          rd_next[ST_PWR_RF]             = pwr_rf;
          rd_next[ST_PWR_IF]             = pwr_if;
          rd_next[ST_RF_B]               = rf_b_sel_reg;
          rd_next[ST_LOCK_LSB +: 3]      = locked;
          rd_next[ST_TUNE_LSB +: 3]      = tuning;
          rd_next[ST_WARN]               = LOCK_MARGIN_WARNING_N;
        end
        OFS_FB_RF:  rd_next[DATA_W:0]    = fb_rf_reg;
        OFS_FB_IF:  rd_next[DATA_W-1:0]  = fb_if_reg;
        OFS_IFDIV:  rd_next[3:0]         = ifdiv_ratio_reg;
        default:    rd_next              = 32'h0000_0000;
      endcase
    end
  end

  // acknowledge and read data
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) begin
        WB_DAT_O <= rd_next;
      end
    end
  end

  // software retune request, a one-cycle pulse taken with the ack edge
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      retune_reg <= 1'b0;
    end else begin
      retune_reg <= WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I &&
                    WB_SEL_I[0] && WB_ADR_I == OFS_CTRL &&
                    WB_DAT_I[CTRL_RETUNE];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  a_wb_answer : assert property (@(posedge REF_CLK) disable iff (RST)
    s_wb_req |=> s_ack_pulse)
    else $error("wishbone ack not one cycle after request");
  a_shadow_latch : assert property (@(posedge REF_CLK) disable iff (RST)
    word_valid |=> shadow_reg[$past(lat_word.addr)] == $past(lat_word.data))
    else $error("latched word not stored at its address");
  a_rf_select : assert property (@(posedge REF_CLK) disable iff (RST)
    word_valid && (lat_word.addr == REG_N_RFB || lat_word.addr == REG_R_RFB)
    |=> rf_b_sel_reg ##1 RF_PLL_B_ACTIVE)
    else $error("writing rf_pll_b did not select it");
  a_one_rf_active : assert property (@(posedge REF_CLK) disable iff (RST)
    !(tuning[0] || locked[0]) || !(tuning[1] || locked[1]))
    else $error("both RF PLLs active");
  a_tune_start : assert property (@(posedge REF_CLK) disable iff (RST)
    tune_start[2] |=> tuning[2] || !powered_prev_reg[2])
    else $error("IF PLL power-up or change did not start tuning");
  a_power_up_start : assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(powered[0]) |-> tune_start[0])
    else $error("rf_pll_a power-up did not start tuning");
  a_warn_tuning : assert property (@(posedge REF_CLK) disable iff (RST)
    (|tuning) |=> LOCK_MARGIN_WARNING_N)
    else $error("warning low while a PLL is tuning");
  a_aux_warn : assert property (@(posedge REF_CLK) disable iff (RST)
    aux_sel == AUX_OUTPUT_SELECT_WARN |=> AUX_OUTPUT_PIN == $past(LOCK_MARGIN_WARNING_N))
    else $error("aux output does not carry the warning");
  a_ifdiv_range : assert property (@(posedge REF_CLK) disable iff (RST)
    $onehot(ifdiv_ratio_reg))
    else $error("IF output divide ratio not 1, 2, 4 or 8");
  a_rf_even : assert property (@(posedge REF_CLK) disable iff (RST)
    !fb_rf_reg[0])
    else $error("RF feedback ratio not twice N");

endmodule : synth_serial_control
`default_nettype wire

// ---- tb/serial_host_model.sv ----
// host model: drives the three-wire programming port on its own link clock
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  output logic sclk,
  output logic serial_data_in,
  output logic sen_n
);
  logic lclk;
  //////////////////////////////////////////////////////////////////////
  // link clock, phase unrelated to the system clock; port idles disabled
  initial begin
    lclk = 1'b0;
    sclk = 1'b0;
    serial_data_in = 1'b0;
    sen_n = 1'b1;
    #137;
    forever #400 lclk = ~lclk;
  end
  // n bits of s msb first; shift clock runs only inside the frame
  task automatic send(input logic [43:0] s, input int n);
    @(negedge lclk) sen_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge lclk) sclk <= 1'b0;
      serial_data_in <= s[i];
      @(posedge lclk) sclk <= 1'b1;
    end
    @(negedge lclk) sclk <= 1'b0;
    serial_data_in <= ~serial_data_in; // released line shows no stale bit
    @(negedge lclk) sen_n <= 1'b1;
  endtask : send
  // clock and data activity while the port is disabled
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge lclk) sclk <= 1'b0;
      serial_data_in <= 1'b1; // shifted ones would land at address 15
      @(posedge lclk) sclk <= 1'b1;
    end
    @(negedge lclk) sclk <= 1'b0;
  endtask : noise
endmodule : serial_host_model
`default_nettype wire

// ---- tb/tb.sv ----
// bench: programs the synthesizer port, checks bus view and warning
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("wrong value at %0t: %0h", $time, a); end end
module tb;
  import synth_ctrl_pkg::*;
  logic        clk, rst, sclk, serial_data_in, sen_n, pd_n, ref_in;
  logic        cyc, stb, we, ack, aux, warn_n, rfb;
  logic [2:0]  near;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dat_o, rdat;
  logic [17:0] nv;
  int          bad_count, samples_checked, cycles, seed;
  word_s       w;
  //////////////////////////////////////////////////////////////////////
  synth_serial_control synth_serial_control_inst (
    .REF_CLK(clk), .RST(rst), .SERIAL_SHIFT_CLOCK(sclk),
    .SERIAL_DATA_IN(serial_data_in), .SERIAL_LATCH_ENABLE_N(sen_n),
    .POWERDOWN_PIN_N(pd_n), .REFERENCE_INPUT(ref_in),
    .COMP_NEAR_LIMIT(near), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .AUX_OUTPUT_PIN(aux), .LOCK_MARGIN_WARNING_N(warn_n),
    .RF_PLL_B_ACTIVE(rfb));
  serial_host_model serial_host_model_inst (
    .sclk(sclk), .serial_data_in(serial_data_in), .sen_n(sen_n));
  //////////////////////////////////////////////////////////////////////
  // system clock, 1 us reference and run limit
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    ref_in <= (cycles % 10) < 5;
    if (cycles == 60000) begin
      bad_count++;
      complete_run();
    end
  end
  // verdict
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // one classic cycle; only the run limit ends a wait for ack
  task automatic wb(input logic w_en, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w_en, a, d, 4'hf};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = dat_o;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask : wb
  // one word with n random leading bits, then let it land
  task automatic prog(input logic [3:0] a, input logic [17:0] d, input int n);
    w.data = d;
    w.addr = a;
    serial_host_model_inst.send({22'($random(seed)), w}, 22 + n);
    repeat (8) @(posedge clk);
  endtask : prog
  // length of one tuning run seen on the warning, h = reference halving
  task automatic tune(input int h);
    int k;
    k = 0;
    while (warn_n !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    `CHK(aux, 1'b1)
    k = 3;
    while (warn_n === 1'b1 && k < 900) begin
      @(posedge clk);
      k++;
    end
    `CHK(k >= 130 * h - 25 && k <= 130 * h + 25, 1'b1)
    repeat (2) @(posedge clk);
    `CHK({aux, warn_n}, 2'b00)
  endtask : tune
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h3249fa37;
    {rst, cyc, stb, we, adr, sel, wdat, pd_n, near, ref_in} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({ack, aux, warn_n, rfb}, 4'b0010)
    for (int i = 0; i < 6; i++) begin
      w.addr = 4'h9 + 4'($unsigned($random(seed)) % 6);
      nv = 18'($random(seed));
      prog(w.addr, nv, $unsigned($random(seed)) % 12);
      wb(1'b0, OFS_SHADOW + {2'b00, w.addr, 2'b00}, 32'h0);
      `CHK(rdat, {14'h0, nv})
    end
    serial_host_model_inst.noise(5);
    serial_host_model_inst.send(44'h0, 0);
    repeat (8) @(posedge clk);
    wb(1'b0, OFS_SHADOW + {2'b00, w.addr, 2'b00}, 32'h0);
    `CHK(rdat, {14'h0, nv})
    wb(1'b0, OFS_SHADOW + 8'h3c, 32'h0);
    `CHK(rdat, 32'h0000_0000)
    nv = 18'($random(seed));
    prog(REG_N_RFB, nv, 0);
    `CHK(rfb, 1'b1)
    wb(1'b0, OFS_FB_RF, 32'h0);
    `CHK(rdat, {13'h0, nv, 1'b0})
    prog(REG_R_RFA, 18'h1, 3);
    `CHK(rfb, 1'b0)
    prog(REG_N_IF, nv, 0);
    wb(1'b0, OFS_FB_IF, 32'h0);
    `CHK(rdat, {14'h0, nv})
    for (int c = 0; c < 4; c++) begin
      prog(REG_MAIN, 18'((c << 1) | 18'h18), 0);
      wb(1'b0, OFS_IFDIV, 32'h0);
      `CHK(rdat, 32'(1 << c))
    end
    wb(1'b0, 8'h20, 32'hffff_ffff);
    `CHK(rdat, 32'h0000_0000)
    prog(REG_POWERDOWN_PIN_N, 18'h3, 0);
    pd_n <= 1'b1;
    tune(1);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rdat, 32'h0000_002b)
    near <= ($random(seed) & 1) ? 3'b001 : 3'b100;
    repeat (6) @(posedge clk);
    `CHK(warn_n, 1'b1)
    near <= 3'b000;
    repeat (6) @(posedge clk);
    `CHK(warn_n, 1'b0)
    prog(REG_MAIN, 18'h58, 0);
    wb(1'b1, OFS_CTRL, 32'h1);
    tune(2);
    prog(REG_N_IF, nv + 18'h1, 0);
    tune(2);
    prog(REG_POWERDOWN_PIN_N, 18'h0, 0);
    prog(REG_POWERDOWN_PIN_N, 18'h3, 0);
    tune(2);
    complete_run();
  end
endmodule : tb
`default_nettype wire
